// ### rtl/bpid_pkg.sv
package bpid_pkg;
    localparam logic [7:0] SYNC1_A = 8'h86;
    localparam logic [7:0] SYNC1_B = 8'h30;
    localparam logic [7:0] SYNC2_A = 8'h79;
    localparam logic [7:0] SYNC2_B = 8'hcf;
    localparam logic [7:0] CMD_ID = 8'hc0;
    localparam logic [7:0] ERR_CMD = 8'ha1;
    localparam logic [7:0] ERR_SEQ = 8'ha3;
    localparam logic [7:0] ERR_LOCK = 8'h63;
    localparam int ERR_REPEAT = 3;
    localparam logic [7:0] START_MARK = 8'h3a;
    localparam logic [7:0] PAYLOAD_COUNT = 8'h13;
    localparam logic [7:0] ADDR_LEN = 8'h03;
    localparam logic [7:0] RSV_FIRST = 8'hfd;
    localparam logic [4:0] FLASH_SIZE_FIELD = 5'h10;
    localparam int FLASH_SIZE_LSB = 3;
    localparam logic [7:0] BLOCK_COUNT = 8'h01;
    localparam logic [23:0] FLASH_FIRST = 24'h008000;
    localparam logic [23:0] FLASH_LAST = 24'h00ffff;
    localparam logic [23:0] RAM_FIRST = 24'h000060;
    localparam logic [23:0] RAM_LAST = 24'h00083f;
    // record bytes 7..27 (start mark through last RAM byte)
    localparam int REC_LEN = 21;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_AW = 4;

    function automatic logic [7:0] bpid_rec_byte(input logic [4:0] idx);
        logic [7:0] size_code;
        size_code = {FLASH_SIZE_FIELD, 3'h0};
        unique case (idx)
            5'd0: bpid_rec_byte = START_MARK;
            5'd1: bpid_rec_byte = PAYLOAD_COUNT;
            5'd2: bpid_rec_byte = ADDR_LEN;
            5'd3: bpid_rec_byte = RSV_FIRST;
            5'd7: bpid_rec_byte = size_code;
            5'd8: bpid_rec_byte = BLOCK_COUNT;
            5'd9: bpid_rec_byte = FLASH_FIRST[23:16];
            5'd10: bpid_rec_byte = FLASH_FIRST[15:8];
            5'd11: bpid_rec_byte = FLASH_FIRST[7:0];
            5'd12: bpid_rec_byte = FLASH_LAST[23:16];
            5'd13: bpid_rec_byte = FLASH_LAST[15:8];
            5'd14: bpid_rec_byte = FLASH_LAST[7:0];
            5'd15: bpid_rec_byte = RAM_FIRST[23:16];
            5'd16: bpid_rec_byte = RAM_FIRST[15:8];
            5'd17: bpid_rec_byte = RAM_FIRST[7:0];
            5'd18: bpid_rec_byte = RAM_LAST[23:16];
            5'd19: bpid_rec_byte = RAM_LAST[15:8];
            5'd20: bpid_rec_byte = RAM_LAST[7:0];
            default: bpid_rec_byte = 8'h00;
        endcase
    endfunction
endpackage

// ### rtl/bpid_link_if.sv
interface bpid_link_if;
    logic [7:0] h2d_data;
    logic h2d_valid;
    logic h2d_ready;
    logic [7:0] d2h_data;
    logic d2h_valid;
    logic d2h_ready;
    logic baud_locked;
    modport dev (input h2d_data, input h2d_valid, output h2d_ready,
        output d2h_data, output d2h_valid, input d2h_ready,
        output baud_locked);
    modport host (output h2d_data, output h2d_valid, input h2d_ready,
        input d2h_data, input d2h_valid, output d2h_ready,
        input baud_locked);
endinterface

// ### rtl/bpid_fifo.sv
module bpid_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    output logic [WIDTH-1:0] o_rd_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        o_wr_ready = (cnt_q != (AW+1)'(DEPTH));
        o_rd_valid = (cnt_q != '0);
        o_rd_data = mem_q[rp_q];
        push = i_wr_valid && o_wr_ready;
        pop = o_rd_valid && i_rd_ready;
        wp_d = push ? wp_q + AW'(1) : wp_q;
        rp_d = pop ? rp_q + AW'(1) : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem_q[wp_q] <= i_wr_data;
        end
    end
endmodule

// ### rtl/bpid_device.sv
module bpid_device (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    bpid_link_if.dev link,
    output logic o_idle_lock,
    output logic [7:0] o_err_code
);
    import bpid_pkg::*;

    typedef enum {
        ST_SYNC1, ST_SYNC2, ST_CMD, ST_RECORD, ST_SUM, ST_ERR, ST_DEAD
    } bpid_dev_state_type;

    bpid_dev_state_type st_q, st_d;
    logic sel_b_q, sel_b_d;
    logic locked_q, locked_d;
    logic [4:0] idx_q, idx_d;
    logic [7:0] sum_q, sum_d;
    logic [1:0] errn_q, errn_d;
    logic [7:0] err_q, err_d;
    logic [7:0] tx_data;
    logic tx_valid, tx_ready;
    logic rx_take;
    logic [7:0] rec_rom [REC_LEN];

    bpid_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txq (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr_data(tx_data),
        .i_wr_valid(tx_valid),
        .o_wr_ready(tx_ready),
        .o_rd_data(link.d2h_data),
        .o_rd_valid(link.d2h_valid),
        .i_rd_ready(link.d2h_ready)
    );

    // record bytes 7 to 27, in send order
    // start mark, payload count
    assign rec_rom[0] = START_MARK;
    assign rec_rom[1] = PAYLOAD_COUNT;
    assign rec_rom[2] = ADDR_LEN;
    assign rec_rom[3] = RSV_FIRST;
    assign rec_rom[4] = 8'h00;
    assign rec_rom[5] = 8'h00;
    assign rec_rom[6] = 8'h00;
    assign rec_rom[7] = 8'(FLASH_SIZE_FIELD) << FLASH_SIZE_LSB;
    assign rec_rom[8] = BLOCK_COUNT;
    assign rec_rom[9] = FLASH_FIRST[23:16];
    assign rec_rom[10] = FLASH_FIRST[15:8];
    assign rec_rom[11] = FLASH_FIRST[7:0];
    assign rec_rom[12] = FLASH_LAST[23:16];
    assign rec_rom[13] = FLASH_LAST[15:8];
    assign rec_rom[14] = FLASH_LAST[7:0];
    assign rec_rom[15] = RAM_FIRST[23:16];
    assign rec_rom[16] = RAM_FIRST[15:8];
    assign rec_rom[17] = RAM_FIRST[7:0];
    assign rec_rom[18] = RAM_LAST[23:16];
    assign rec_rom[19] = RAM_LAST[15:8];
    assign rec_rom[20] = RAM_LAST[7:0];

    always_comb begin
        st_d = st_q;
        sel_b_d = sel_b_q;
        locked_d = locked_q;
        idx_d = idx_q;
        sum_d = sum_q;
        errn_d = errn_q;
        err_d = err_q;
        tx_data = 8'h00;
        tx_valid = 1'b0;
        // receive only when an echo can be queued, except ST_DEAD, which takes every byte
        rx_take = 1'b0;
        link.h2d_ready = 1'b0;
        unique case (st_q)
            ST_SYNC1: begin
                link.h2d_ready = tx_ready;
                rx_take = link.h2d_valid && tx_ready;
                if (rx_take && (link.h2d_data == SYNC1_A ||
                        link.h2d_data == SYNC1_B)) begin
                    sel_b_d = (link.h2d_data == SYNC1_B);
                    locked_d = 1'b1;
                    tx_data = link.h2d_data;
                    tx_valid = 1'b1;
                    st_d = ST_SYNC2;
                end
            end
            ST_SYNC2: begin
                link.h2d_ready = tx_ready;
                rx_take = link.h2d_valid && tx_ready;
                if (rx_take) begin
                    if (link.h2d_data == (sel_b_q ? SYNC2_B : SYNC2_A)) begin
                        tx_data = link.h2d_data;
                        tx_valid = 1'b1;
                        st_d = ST_CMD;
                    end else begin
                        st_d = ST_DEAD;
                    end
                end
            end
            ST_CMD: begin
                link.h2d_ready = tx_ready;
                rx_take = link.h2d_valid && tx_ready;
                if (rx_take) begin
                    if (link.h2d_data == CMD_ID) begin
                        tx_data = CMD_ID;
                        tx_valid = 1'b1;
                        idx_d = '0;
                        sum_d = 8'h00;
                        st_d = ST_RECORD;
                    end else begin
                        err_d = ERR_CMD;
                        errn_d = '0;
                        st_d = ST_ERR;
                    end
                end
            end
            ST_RECORD: begin
                // host held off, no receive in this state
                tx_data = rec_rom[idx_q];
                tx_valid = 1'b1;
                // stalls while the queue is full
                if (tx_ready) begin
                    if (idx_q >= 5'd2) begin
                        sum_d = sum_q + tx_data;
                    end
                    idx_d = idx_q + 5'd1;
                    if (idx_q == 5'(REC_LEN - 1)) begin
                        st_d = ST_SUM;
                    end
                end
            end
            ST_SUM: begin
                tx_data = 8'(~sum_q + 8'h01);
                tx_valid = 1'b1;
                if (tx_ready) begin
                    st_d = ST_CMD;
                end
            end
            ST_ERR: begin
                tx_data = err_q;
                tx_valid = 1'b1;
                if (tx_ready) begin
                    errn_d = errn_q + 2'd1;
                    if (errn_q == 2'(ERR_REPEAT - 1)) begin
                        st_d = ST_DEAD;
                    end
                end
            end
            ST_DEAD: begin
                link.h2d_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st_q <= ST_SYNC1;
            sel_b_q <= 1'b0;
            locked_q <= 1'b0;
            idx_q <= '0;
            sum_q <= 8'h00;
            errn_q <= '0;
            err_q <= 8'h00;
        end else begin
            st_q <= st_d;
            sel_b_q <= sel_b_d;
            locked_q <= locked_d;
            idx_q <= idx_d;
            sum_q <= sum_d;
            errn_q <= errn_d;
            err_q <= err_d;
        end
    end

    assign link.baud_locked = locked_q;
    assign o_idle_lock = (st_q == ST_DEAD);
    assign o_err_code = err_q;
endmodule

// ### rtl/bpid_host.sv
module bpid_host (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    bpid_link_if.host link,
    input wire logic i_start,
    input wire logic i_use_alt,
    output logic o_busy,
    output logic o_done,
    output logic o_fail,
    output logic [7:0] o_size_code,
    output logic [7:0] o_last_byte
);
    import bpid_pkg::*;

    typedef enum {
        HS_IDLE, HS_TX, HS_RX, HS_DONE, HS_FAIL
    } bpid_host_state_type;

    bpid_host_state_type st_q, st_d;
    logic alt_q, alt_d;
    logic [1:0] step_q, step_d;
    logic [4:0] n_q, n_d;
    logic [7:0] sum_q, sum_d;
    logic [7:0] size_q, size_d;
    logic [7:0] last_q, last_d;
    logic [7:0] want;

    always_comb begin
        st_d = st_q;
        alt_d = alt_q;
        step_d = step_q;
        n_d = n_q;
        sum_d = sum_q;
        size_d = size_q;
        last_d = last_q;
        unique case (step_q)
            2'd0: want = alt_q ? SYNC1_B : SYNC1_A;
            2'd1: want = alt_q ? SYNC2_B : SYNC2_A;
            default: want = CMD_ID;
        endcase
        link.h2d_data = want;
        link.h2d_valid = (st_q == HS_TX);
        link.d2h_ready = (st_q == HS_RX);
        unique case (st_q)
            HS_IDLE: begin
                if (i_start) begin
                    alt_d = i_use_alt;
                    step_d = 2'd0;
                    st_d = HS_TX;
                end
            end
            HS_TX: begin
                if (link.h2d_ready) begin
                    n_d = '0;
                    sum_d = 8'h00;
                    st_d = HS_RX;
                end
            end
            HS_RX: begin
                if (link.d2h_valid) begin
                    last_d = link.d2h_data;
                    if (step_q != 2'd2) begin
                        if (link.d2h_data != want) begin
                            st_d = HS_FAIL;
                        end else begin
                            step_d = step_q + 2'd1;
                            st_d = HS_TX;
                        end
                    end else begin
                        n_d = n_q + 5'd1;
                        if (n_q == 5'd0 && link.d2h_data != CMD_ID) begin
                            st_d = HS_FAIL;
                        end
                        if (n_q >= 5'd3) begin
                            sum_d = sum_q + link.d2h_data;
                        end
                        if (n_q == 5'd8) begin
                            size_d = link.d2h_data;
                        end
                        if (n_q == 5'(REC_LEN + 1)) begin
                            st_d = (sum_d == 8'h00) ? HS_DONE : HS_FAIL;
                        end
                    end
                end
            end
            HS_DONE, HS_FAIL: begin
                if (i_start) begin
                    alt_d = i_use_alt;
                    step_d = (st_q == HS_DONE) ? 2'd2 : 2'd0;
                    st_d = HS_TX;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st_q <= HS_IDLE;
            alt_q <= 1'b0;
            step_q <= 2'd0;
            n_q <= '0;
            sum_q <= 8'h00;
            size_q <= 8'h00;
            last_q <= 8'h00;
        end else begin
            st_q <= st_d;
            alt_q <= alt_d;
            step_q <= step_d;
            n_q <= n_d;
            sum_q <= sum_d;
            size_q <= size_d;
            last_q <= last_d;
        end
    end

    assign o_busy = (st_q == HS_TX) || (st_q == HS_RX);
    assign o_done = (st_q == HS_DONE);
    assign o_fail = (st_q == HS_FAIL);
    assign o_size_code = size_q;
    assign o_last_byte = last_q;
endmodule

// ### tb/bpid_link_properties.sv
module bpid_link_properties
    import bpid_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] h2d_data,
    input wire logic h2d_valid,
    input wire logic h2d_ready,
    input wire logic [7:0] d2h_data,
    input wire logic d2h_valid,
    input wire logic d2h_ready,
    input wire logic baud_locked
);
    logic take;
    logic [4:0] rec_cnt_q, rec_cnt_d;
    logic [7:0] sum_q, sum_d;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    // bytes left in the record, checksum last
    assign take = d2h_valid && d2h_ready;
    always_comb begin
        rec_cnt_d = rec_cnt_q;
        sum_d = sum_q;
        if (take && rec_cnt_q == 5'h0 && d2h_data == CMD_ID) begin
            rec_cnt_d = 5'h16;
            sum_d = 8'h00;
        end else if (take && rec_cnt_q != 5'h0) begin
            rec_cnt_d = rec_cnt_q - 5'h1;
            if (rec_cnt_q >= 5'h2 && rec_cnt_q <= 5'h14) begin
                sum_d = sum_q + d2h_data;
            end
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rec_cnt_q <= 5'h0;
            sum_q <= 8'h00;
        end else begin
            rec_cnt_q <= rec_cnt_d;
            sum_q <= sum_d;
        end
    end

    chk_sync_echo: assert property (
        !baud_locked && h2d_valid && h2d_ready &&
        (h2d_data == 8'h86 || h2d_data == 8'h30) |=> baud_locked &&
        d2h_valid && d2h_data == $past(h2d_data))
        else $error("first sync byte not echoed");
    chk_cmd_ack: assert property (
        baud_locked && h2d_valid && h2d_ready && h2d_data == 8'hc0
        |=> d2h_valid && d2h_data == 8'hc0)
        else $error("command not acknowledged");
    chk_mark_first: assert property (
        take && rec_cnt_q == 5'h16 |-> d2h_data == 8'h3a)
        else $error("start mark missing");
    chk_count_next: assert property (
        take && rec_cnt_q == 5'h15 |-> d2h_data == 8'h13)
        else $error("byte count wrong");
    chk_addr_len: assert property (
        take && rec_cnt_q == 5'h14 |-> d2h_data == 8'h03)
        else $error("address length wrong");
    chk_size_code: assert property (
        take && rec_cnt_q == 5'hf |-> d2h_data[2:0] == 3'h0 &&
        d2h_data[7:3] == 5'h10)
        else $error("size code wrong");
    chk_block_one: assert property (
        take && rec_cnt_q == 5'he |-> d2h_data == 8'h01)
        else $error("block count wrong");
    chk_sum_zero: assert property (
        take && rec_cnt_q == 5'h1 |-> 8'(sum_q + d2h_data) == 8'h00)
        else $error("checksum wrong");
    chk_host_quiet: assert property (
        rec_cnt_q != 5'h0 |-> !h2d_valid)
        else $error("host sent during record");
    chk_rate_kept: assert property (
        baud_locked |=> baud_locked)
        else $error("rate lock lost");
    chk_rsv_first: assert property (
        take && rec_cnt_q == 5'h13 |-> d2h_data == 8'hfd)
        else $error("first reserved byte wrong");
    chk_flash_first: assert property (
        take && rec_cnt_q == 5'hc |-> d2h_data == 8'h80)
        else $error("flash first address wrong");
    chk_ram_last: assert property (
        take && rec_cnt_q == 5'h2 |-> d2h_data == 8'h3f)
        else $error("loader last address wrong");

    cov_record: cover property (take && rec_cnt_q == 5'h1);
    cov_sync: cover property (h2d_valid && h2d_ready && !baud_locked);
    cov_stall: cover property (d2h_valid && !d2h_ready);
endmodule

// ### tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bpid_pkg::*;
    logic i_core_clk = 1'h0;
    logic i_sys_rst = 1'h1;
    logic i_start = 1'h0;
    logic i_use_alt = 1'h0;
    logic busy, done, fail, lock_a, lock_b;
    logic [7:0] size_code, last_byte, err_a, err_b;
    logic [7:0] rec [0:22];
    logic [7:0] dq [$];
    logic [7:0] hq [$];
    int mismatches = 0;
    int n_checks = 0;

    bpid_link_if link_a ();
    bpid_link_if link_b ();
    bpid_host u_bpid_host (.i_core_clk, .i_sys_rst, .link(link_a),
        .i_start, .i_use_alt, .o_busy(busy), .o_done(done),
        .o_fail(fail), .o_size_code(size_code), .o_last_byte(last_byte));
    bpid_device u_bpid_device (.i_core_clk, .i_sys_rst, .link(link_a),
        .o_idle_lock(lock_a), .o_err_code(err_a));
    // second device faces the bench acting as a faulty host
    bpid_device u_bpid_device2 (.i_core_clk, .i_sys_rst, .link(link_b),
        .o_idle_lock(lock_b), .o_err_code(err_b));
    bpid_link_properties u_bpid_link_properties (.i_core_clk, .i_sys_rst,
        .h2d_data(link_a.h2d_data), .h2d_valid(link_a.h2d_valid),
        .h2d_ready(link_a.h2d_ready), .d2h_data(link_a.d2h_data),
        .d2h_valid(link_a.d2h_valid), .d2h_ready(link_a.d2h_ready),
        .baud_locked(link_a.baud_locked));

    initial begin
        forever #20 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk) begin
        if (link_a.d2h_valid === 1'h1 && link_a.d2h_ready === 1'h1) begin
            dq.push_back(link_a.d2h_data);
        end
        if (link_a.h2d_valid === 1'h1 && link_a.h2d_ready === 1'h1) begin
            hq.push_back(link_a.h2d_data);
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        check8({7'h0, got}, {7'h0, exp});
    endtask

    task automatic expire(input int n);
        if (n > 400) begin
            check1(1'h0, 1'h1);
            tally_and_finish();
        end
    endtask

    task automatic send_b(input logic [7:0] b);
        int n;
        n = 0;
        link_b.h2d_data = b;
        link_b.h2d_valid = 1'h1;
        while (link_b.h2d_ready !== 1'h1) begin
            @(posedge i_core_clk);
            #1;
            n++;
            expire(n);
        end
        @(posedge i_core_clk);
        #1;
        link_b.h2d_valid = 1'h0;
        link_b.h2d_data = ~b;
    endtask

    task automatic recv_b(input logic [7:0] exp, input logic last);
        int n;
        logic [7:0] got;
        n = 0;
        link_b.d2h_ready = 1'h1;
        while (link_b.d2h_valid !== 1'h1) begin
            @(posedge i_core_clk);
            #1;
            n++;
            expire(n);
        end
        got = link_b.d2h_data;
        @(posedge i_core_clk);
        #1;
        // ready stays up between back-to-back reads
        if (last) link_b.d2h_ready = 1'h0;
        check8(got, exp);
    endtask

    task automatic quiet_b(input int cycles);
        logic seen;
        seen = 1'h0;
        repeat (cycles) begin
            @(posedge i_core_clk);
            #1;
            if (link_b.d2h_valid === 1'h1) seen = 1'h1;
        end
        check1(seen, 1'h0);
    endtask

    task automatic run_host;
        int n;
        n = 0;
        dq.delete();
        hq.delete();
        i_start = 1'h1;
        @(posedge i_core_clk);
        #1;
        i_start = 1'h0;
        check1(busy, 1'h1);
        while (done !== 1'h1) begin
            @(posedge i_core_clk);
            #1;
            n++;
            expire(n);
        end
        check1(busy, 1'h0);
    endtask

    task automatic do_reset;
        i_sys_rst = 1'h1;
        repeat (6) @(posedge i_core_clk);
        #1;
        i_sys_rst = 1'h0;
    endtask

    initial begin
        logic [7:0] sum;
        link_b.h2d_data = 8'h00;
        link_b.h2d_valid = 1'h0;
        link_b.d2h_ready = 1'h0;
        rec = '{8'hc0, 8'h3a, 8'h13, 8'h03, 8'hfd, 8'h00, 8'h00, 8'h00,
            8'h80, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00,
            8'h00, 8'h60, 8'h00, 8'h08, 8'h3f, 8'h00};
        sum = 8'h00;
        for (int i = 3; i < 22; i++) sum = sum + rec[i];
        rec[22] = 8'h00 - sum;
        do_reset();
        run_host();
        check1(fail, 1'h0);
        check1(lock_a, 1'h0);
        check8(err_a, 8'h00);
        check8(size_code, 8'h80);
        check8(last_byte, rec[22]);
        check8(hq[0], 8'h86);
        check8(dq[0], 8'h86);
        check8(hq[1], 8'h79);
        check8(dq[1], 8'h79);
        check8(hq[2], 8'hc0);
        check8(8'(dq.size()), 8'h19);
        for (int i = 0; i < 23; i++) check8(dq[i + 2], rec[i]);
        $display("test session done");
        run_host();
        check8(8'(dq.size()), 8'h17);
        for (int i = 0; i < 23; i++) check8(dq[i], rec[i]);
        $display("test next command done");
        send_b(8'h55);
        quiet_b(10);
        check1(link_b.baud_locked, 1'h0);
        send_b(8'h30);
        recv_b(8'h30, 1'h1);
        check1(link_b.baud_locked, 1'h1);
        send_b(8'hcf);
        recv_b(8'hcf, 1'h1);
        send_b(8'hc0);
        repeat (60) @(posedge i_core_clk);
        #1;
        check1(link_b.h2d_ready, 1'h0);
        check1(link_b.d2h_valid, 1'h1);
        for (int i = 0; i < 23; i++) recv_b(rec[i], i == 22);
        quiet_b(4);
        $display("test stalled record done");
        send_b(8'h12);
        for (int i = 0; i < 3; i++) recv_b(8'ha1, i == 2);
        check1(lock_b, 1'h1);
        check8(err_b, 8'ha1);
        send_b(8'hc0);
        quiet_b(40);
        $display("test bad command done");
        do_reset();
        send_b(8'h86);
        recv_b(8'h86, 1'h1);
        send_b(8'hcf);
        quiet_b(10);
        send_b(8'hc0);
        quiet_b(40);
        check1(lock_b, 1'h1);
        $display("test bad sync done");
        i_use_alt = 1'h1;
        run_host();
        check1(fail, 1'h0);
        check8(hq[0], 8'h30);
        check8(dq[0], 8'h30);
        check8(hq[1], 8'hcf);
        check8(dq[1], 8'hcf);
        check8(8'(dq.size()), 8'h19);
        for (int i = 0; i < 23; i++) check8(dq[i + 2], rec[i]);
        $display("test alternate sync done");
        tally_and_finish();
    end
endmodule
